// File: hdl/ldm_pkg.sv
/*
  Package for the logical DMA lane B/C mode block: register offsets, field
  positions, reset values and transfer-type codes.
  Assumes an 8-bit host register port with a 4-bit address and write strobe.
*/
package ldm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] LDM_LANE_B_MODE_OFS = 4'h5;
  localparam logic [3:0] LDM_LANE_C_MODE_OFS = 4'h7;
  localparam logic [3:0] LDM_STROBE_OFS = 4'h1;
  localparam logic [7:0] LDM_MODE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Mode register fields and strobe register bits
  // ----------------------------------------------------------------
  localparam int LDM_PATH_ON_BIT = 7;
  localparam int LDM_IRQ_ON_BIT = 6;
  localparam int LDM_XFER_HI = 5;
  localparam int LDM_XFER_LO = 3;
  localparam int LDM_PHYS_HI = 2;
  localparam int LDM_PHYS_LO = 0;
  localparam int LDM_CLR_B_BIT = 1;
  localparam int LDM_CLR_C_BIT = 2;

  // ----------------------------------------------------------------
  // Transfer types, burst length and physical channel count
  // ----------------------------------------------------------------
  localparam logic [2:0] LDM_XFER_SINGLE = 3'h0;
  localparam logic [2:0] LDM_XFER_BURST = 3'h1;
  localparam int LDM_BURST_LEN = 8;
  localparam int LDM_PHYS_CHANS = 8;

endpackage : ldm_pkg

// File: hdl/ldm_lane_bc.sv
/*
  Mode control for logical DMA lanes B and C: two write-only mode registers,
  logical request to physical request/acknowledge translation with single or
  burst behaviour, a two-entry buffer per lane, and terminal-count interrupts.
  Assumes host writes arrive synchronous to ref_clk_i and that physical DMA
  acknowledge and terminal-count pins arrive asynchronously.
*/
`timescale 1ns/1ns
module ldm_lane_bc
  import ldm_pkg::*;
#(
  parameter int WIDTH = 16,        // Data word width
  parameter int NCHAN = LDM_PHYS_CHANS // Physical channel count
) (
  input wire logic ref_clk_i,                    // Board clock, 125 MHz
  input wire logic reset_i,                      // Board reset, sync, high
  input wire logic wr_en_i,                      // Host register write strobe
  input wire logic [3:0] wr_addr_i,              // Host register offset
  input wire logic [7:0] wr_data_i,              // Host write data
  input wire logic [1:0] lreq_valid_i,           // Logical word valid, [0]=B [1]=C
  input wire logic [2*WIDTH-1:0] lreq_data_i,    // Logical words, B in low half
  output logic [1:0] lreq_ready_o,               // Buffer can take a word
  output logic [NCHAN-1:0] dma_req_o,            // Physical DMA requests
  input wire logic [NCHAN-1:0] dma_ack_i,        // Physical DMA acks, async
  output logic [WIDTH-1:0] dma_data_o,           // Word for acked transfer
  input wire logic [1:0] tc_i,                   // Terminal count per lane, async
  output logic [1:0] count_done_o,               // Count status B, C
  output logic irq_o                             // Terminal-count interrupt
);

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic [7:0] mode_q [2];
  logic [1:0] wr_mode;
  logic [1:0] clr_hit;
  assign wr_mode[0] = wr_en_i && (wr_addr_i == LDM_LANE_B_MODE_OFS);
  assign wr_mode[1] = wr_en_i && (wr_addr_i == LDM_LANE_C_MODE_OFS);
  // The strobe bits exist only as decode terms, so they self-clear
  assign clr_hit[0] = wr_en_i && (wr_addr_i == LDM_STROBE_OFS) && wr_data_i[LDM_CLR_B_BIT];
  assign clr_hit[1] = wr_en_i && (wr_addr_i == LDM_STROBE_OFS) && wr_data_i[LDM_CLR_C_BIT];

  // Mode registers, cleared by board reset; one process drives both
  always_ff @(posedge ref_clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (reset_i) begin
        mode_q[i] <= LDM_MODE_RESET;
      end else if (wr_mode[i]) begin
        mode_q[i] <= wr_data_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers for asynchronous pins
  // ----------------------------------------------------------------
  logic [NCHAN-1:0] ack_s1_q, ack_s2_q;
  logic [1:0] tc_s1_q, tc_s2_q, tc_s3_q;
  always_ff @(posedge ref_clk_i) begin
    ack_s1_q <= dma_ack_i;
    ack_s2_q <= ack_s1_q;
    tc_s1_q <= tc_i;
    tc_s2_q <= tc_s1_q;
    tc_s3_q <= tc_s2_q;
  end
  logic [1:0] tc_rise;
  assign tc_rise = tc_s2_q & ~tc_s3_q;

  // ----------------------------------------------------------------
  // Per-lane logic, lane C identical to lane B
  // ----------------------------------------------------------------
  logic [1:0] lane_req;
  logic [1:0] lane_ack;
  logic [1:0] lane_ack_rise;
  logic [2:0] lane_sel [2];
  logic [WIDTH-1:0] lane_head [2];
  logic [1:0] count_done_q;
  logic [NCHAN-1:0] req_b, req_c;

  for (genvar l = 0; l < 2; l++) begin : g_lane
    logic on;
    logic burst;
    logic [1:0] cnt_q;
    logic [WIDTH-1:0] buf_q [2];
    logic wp_q, rp_q;
    logic ack_d_q;
    logic [3:0] burst_q;
    logic push, pop;

    assign on = mode_q[l][LDM_PATH_ON_BIT];
    // Only code 1 bursts; reserved codes fall back to single transfers
    assign burst = (mode_q[l][LDM_XFER_HI:LDM_XFER_LO] == LDM_XFER_BURST);
    assign lane_sel[l] = mode_q[l][LDM_PHYS_HI:LDM_PHYS_LO];
    assign lane_ack[l] = ack_s2_q[lane_sel[l]];
    assign lane_ack_rise[l] = lane_ack[l] && !ack_d_q;

    // Two-entry buffer; disabled lane refuses and flushes words
    assign lreq_ready_o[l] = on && (cnt_q != 2'd2);
    assign push = lreq_valid_i[l] && lreq_ready_o[l];
    assign pop = on && lane_ack_rise[l] && (cnt_q != 2'd0);
    assign lane_head[l] = buf_q[rp_q];

    always_ff @(posedge ref_clk_i) begin
      if (reset_i || !on) begin
        cnt_q <= 2'd0;
        wp_q <= 1'b0;
        rp_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        if (push) wp_q <= ~wp_q;
        if (pop) rp_q <= ~rp_q;
      end
    end

    always_ff @(posedge ref_clk_i) begin
      if (push) buf_q[wp_q] <= lreq_data_i[l*WIDTH +: WIDTH];
    end

    // Burst counter: request held across up to eight acknowledged transfers
    always_ff @(posedge ref_clk_i) begin
      if (reset_i || !on) begin
        ack_d_q <= 1'b0;
        burst_q <= 4'h0;
      end else begin
        ack_d_q <= lane_ack[l];
        if (!burst || cnt_q == 2'd0) begin
          burst_q <= 4'h0;
        end else if (pop) begin
          burst_q <= (burst_q == 4'(LDM_BURST_LEN - 1)) ? 4'h0 : burst_q + 4'h1;
        end
      end
    end

    // Single mode drops request while ack is high to force rearbitration
    assign lane_req[l] = on && (cnt_q != 2'd0) &&
                         (burst ? !(lane_ack[l] && burst_q == 4'(LDM_BURST_LEN - 1))
                                : !lane_ack[l]);

  end

  // Count status: a terminal count in the same cycle as a clear wins,
  // so an event is never lost to a strobe already in flight
  always_ff @(posedge ref_clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (reset_i) begin
        count_done_q[i] <= 1'b0;
      end else if (tc_rise[i] && mode_q[i][LDM_PATH_ON_BIT]) begin
        count_done_q[i] <= 1'b1;
      end else if (clr_hit[i]) begin
        count_done_q[i] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Physical request mapping and outputs
  // ----------------------------------------------------------------
  assign req_b = lane_req[0] ? (NCHAN'(1) << lane_sel[0]) : '0;
  assign req_c = lane_req[1] ? (NCHAN'(1) << lane_sel[1]) : '0;
  assign count_done_o = count_done_q;
  assign irq_o = (count_done_q[0] && mode_q[0][LDM_IRQ_ON_BIT]) ||
                 (count_done_q[1] && mode_q[1][LDM_IRQ_ON_BIT]);

  // Registered request and data; B wins if both lanes share an ack
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      dma_req_o <= '0;
      dma_data_o <= '0;
    end else begin
      dma_req_o <= req_b | req_c;
      if (g_lane[0].pop) begin
        dma_data_o <= lane_head[0];
      end else if (g_lane[1].pop) begin
        dma_data_o <= lane_head[1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_reset_clear;
    @(posedge ref_clk_i) reset_i |=> (mode_q[0] == LDM_MODE_RESET && mode_q[1] == LDM_MODE_RESET);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("mode not cleared by reset");

  property p_write_b;
    @(posedge ref_clk_i) disable iff (reset_i) wr_mode[0] |=> mode_q[0] == $past(wr_data_i);
  endproperty
  a_write_b: assert property (p_write_b) else $error("lane B write lost");

  property p_off_no_req;
    @(posedge ref_clk_i) disable iff (reset_i)
      !mode_q[0][LDM_PATH_ON_BIT] && !mode_q[1][LDM_PATH_ON_BIT] |=> dma_req_o == '0;
  endproperty
  a_off_no_req: assert property (p_off_no_req) else $error("request while lanes off");

  property p_off_refuse;
    @(posedge ref_clk_i) disable iff (reset_i)
      !mode_q[1][LDM_PATH_ON_BIT] |-> !lreq_ready_o[1] ##1 g_lane[1].cnt_q == 2'd0;
  endproperty
  a_off_refuse: assert property (p_off_refuse) else $error("disabled lane accepted word");

  property p_irq_gate;
    @(posedge ref_clk_i) disable iff (reset_i)
      !mode_q[0][LDM_IRQ_ON_BIT] && !mode_q[1][LDM_IRQ_ON_BIT] |-> !irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt while gated");

  property p_single_drop;
    @(posedge ref_clk_i) disable iff (reset_i)
      lane_req[0] && !g_lane[0].burst && lane_ack[0] |-> 1'b0;
  endproperty
  a_single_drop: assert property (p_single_drop) else $error("single kept request during ack");

  property p_burst_cap;
    @(posedge ref_clk_i) disable iff (reset_i) g_lane[0].burst_q < 4'(LDM_BURST_LEN);
  endproperty
  a_burst_cap: assert property (p_burst_cap) else $error("burst beyond eight");

  property p_sel_map;
    @(posedge ref_clk_i) disable iff (reset_i) lane_req[0] |=> dma_req_o[$past(lane_sel[0])];
  endproperty
  a_sel_map: assert property (p_sel_map) else $error("request on wrong channel");

  property p_clear_tc;
    @(posedge ref_clk_i) disable iff (reset_i) clr_hit[1] && !tc_rise[1] |=> !count_done_o[1];
  endproperty
  a_clear_tc: assert property (p_clear_tc) else $error("clear strobe ignored");

  property p_reserved_single;
    @(posedge ref_clk_i) disable iff (reset_i)
      mode_q[1][LDM_XFER_HI:LDM_XFER_LO] > LDM_XFER_BURST |-> !g_lane[1].burst;
  endproperty
  a_reserved_single: assert property (p_reserved_single) else $error("reserved type bursts");

  property p_write_c;
    @(posedge ref_clk_i) disable iff (reset_i) wr_mode[1] |=> mode_q[1] == $past(wr_data_i);
  endproperty
  a_write_c: assert property (p_write_c) else $error("lane C write lost");

  property p_reset_status;
    @(posedge ref_clk_i) reset_i |=> (count_done_o == 2'b00 && dma_req_o == '0);
  endproperty
  a_reset_status: assert property (p_reset_status) else $error("status not cleared by reset");

  property p_sel_map_c;
    @(posedge ref_clk_i) disable iff (reset_i) lane_req[1] |=> dma_req_o[$past(lane_sel[1])];
  endproperty
  a_sel_map_c: assert property (p_sel_map_c) else $error("lane C request on wrong channel");

  // Synchronised ack of a single-mode lane B transfer, lane C quiet
  sequence s_single_ack_b;
    g_lane[0].on && !g_lane[0].burst && lane_ack[0] && !lane_req[1];
  endsequence

  property p_single_release;
    @(posedge ref_clk_i) disable iff (reset_i) s_single_ack_b |=> !dma_req_o[$past(lane_sel[0])];
  endproperty
  a_single_release: assert property (p_single_release) else $error("single request not released");

  // Lane C burst ack before the eighth transfer, with words still queued
  sequence s_burst_mid_ack_c;
    g_lane[1].on && g_lane[1].burst && lane_ack[1] && g_lane[1].cnt_q != 2'd0 &&
    g_lane[1].burst_q != 4'(LDM_BURST_LEN - 1);
  endsequence

  // Lane C burst ack that completes eight transfers, lane B quiet
  sequence s_burst_last_ack_c;
    g_lane[1].burst && lane_ack[1] && !lane_req[0] &&
    g_lane[1].burst_q == 4'(LDM_BURST_LEN - 1);
  endsequence

  property p_burst_hold;
    @(posedge ref_clk_i) disable iff (reset_i) s_burst_mid_ack_c |=> dma_req_o[$past(lane_sel[1])];
  endproperty
  a_burst_hold: assert property (p_burst_hold) else $error("burst request dropped early");

  property p_burst_release;
    @(posedge ref_clk_i) disable iff (reset_i) s_burst_last_ack_c |=> !dma_req_o[$past(lane_sel[1])];
  endproperty
  a_burst_release: assert property (p_burst_release) else $error("burst held past eight");

  property p_data_pop;
    @(posedge ref_clk_i) disable iff (reset_i) g_lane[0].pop |=> dma_data_o == $past(lane_head[0]);
  endproperty
  a_data_pop: assert property (p_data_pop) else $error("acked word not presented");

  property p_tc_set;
    @(posedge ref_clk_i) disable iff (reset_i) tc_rise[0] && mode_q[0][LDM_PATH_ON_BIT] |=> count_done_o[0];
  endproperty
  a_tc_set: assert property (p_tc_set) else $error("count event lost");

  property p_clear_tc_b;
    @(posedge ref_clk_i) disable iff (reset_i) clr_hit[0] && !tc_rise[0] |=> !count_done_o[0];
  endproperty
  a_clear_tc_b: assert property (p_clear_tc_b) else $error("lane B clear strobe ignored");

  property p_irq_own_gate;
    @(posedge ref_clk_i) disable iff (reset_i)
      !(count_done_o[0] && mode_q[0][LDM_IRQ_ON_BIT]) && !mode_q[1][LDM_IRQ_ON_BIT] |-> !irq_o;
  endproperty
  a_irq_own_gate: assert property (p_irq_own_gate) else $error("lane C interrupt not gated");

  property p_irq_raise;
    @(posedge ref_clk_i) disable iff (reset_i) count_done_o[0] && mode_q[0][LDM_IRQ_ON_BIT] |-> irq_o;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("enabled interrupt missing");

endmodule : ldm_lane_bc

// File: test/ldm_host_dma.sv
/*
  Host DMA controller model: grants one physical request at a time.
  Assumes requests are registered on the board clock; acks are async.
*/
`timescale 1ns/1ns
module ldm_host_dma (
  input wire logic clk_i, // Board clock
  input wire logic slow_i, // Add ack latency
  input wire logic [7:0] req_i, // Physical requests
  input wire logic [15:0] data_i, // Word of acked transfer
  output logic [7:0] ack_o, // Physical acks
  output logic took_o, // Result flag, one cycle
  output logic [2:0] ch_o, // Channel granted
  output logic low_o, // Request dropped after ack
  output logic [15:0] word_o // Word captured
);
  // ------------------------------
  // Grant loop
  // ------------------------------
  // Gaps between acks let the two-flop sync settle before the next look
  initial begin
    ack_o = '0;
    took_o = 1'b0;
    ch_o = 3'h0;
    low_o = 1'b0;
    word_o = 16'h0000;
    forever begin
      @(negedge clk_i);
      took_o = 1'b0;
      if (|req_i) begin
        ch_o = 3'h0;
        while (!req_i[ch_o]) ch_o = ch_o + 3'h1;
        repeat (slow_i ? 6 : 0) @(negedge clk_i);
        ack_o[ch_o] = 1'b1;
        @(negedge clk_i);
        ack_o = '0;
        low_o = 1'b0;
        repeat (4) begin
          @(negedge clk_i);
          if (!req_i[ch_o]) low_o = 1'b1;
        end
        word_o = data_i;
        took_o = 1'b1;
      end
    end
  end
endmodule : ldm_host_dma

// File: test/ldm_lane_bc_bench.sv
/*
  Bench for the lane B/C mode block facing a host DMA model.
  Assumes the package and the design are compiled first.
*/
`timescale 1ns/1ns
module ldm_lane_bc_bench;
  import ldm_pkg::*;
  logic ref_clk_i, reset_i, wr_en_i, slow, irq_o, took, low;
  logic [3:0] wr_addr_i;
  logic [7:0] wr_data_i, dma_req_o, dma_ack_i;
  logic [1:0] lreq_valid_i, lreq_ready_o, tc_i, count_done_o;
  logic [31:0] lreq_data_i;
  logic [15:0] dma_data_o, word;
  logic [2:0] ch;
  logic [19:0] q[$];
  logic [19:0] e;
  int mismatches, n_tests;
  ldm_lane_bc dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i), .lreq_valid_i(lreq_valid_i), .lreq_data_i(lreq_data_i),
    .lreq_ready_o(lreq_ready_o), .dma_req_o(dma_req_o), .dma_ack_i(dma_ack_i), .dma_data_o(dma_data_o),
    .tc_i(tc_i), .count_done_o(count_done_o), .irq_o(irq_o));
  ldm_host_dma host (.clk_i(ref_clk_i), .slow_i(slow), .req_i(dma_req_o), .data_i(dma_data_o),
    .ack_o(dma_ack_i), .took_o(took), .ch_o(ch), .low_o(low), .word_o(word));
  // Board clock, 8 ns
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // ------------------------------
  // Shared tasks
  // ------------------------------
  task check(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      mismatches++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : check
  task final_report;
    $display("tests=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    wr_en_i = 1'b1;
    wr_addr_i = a;
    wr_data_i = d;
    @(negedge ref_clk_i);
    wr_en_i = 1'b0;
  endtask : wr
  // Word is taken at the edge after ready is seen high; note it first.
  // lo is whether the host should see the request drop after this ack.
  task push(input int l, input logic [2:0] c, input logic lo);
    int k;
    logic [15:0] w;
    w = 16'($urandom);
    @(negedge ref_clk_i);
    lreq_valid_i[l] = 1'b1;
    lreq_data_i[l*16 +: 16] = w;
    for (k = 0; !lreq_ready_o[l]; k++) begin
      if (k == 200) begin
        mismatches++;
        final_report();
      end
      @(negedge ref_clk_i);
    end
    q.push_back({lo, c, w});
    @(negedge ref_clk_i);
    lreq_valid_i[l] = 1'b0;
  endtask : push
  task drain;
    for (int k = 0; q.size() > 0; k++) begin
      if (k == 500) begin
        mismatches++;
        final_report();
      end
      @(negedge ref_clk_i);
    end
  endtask : drain
  // Oldest note against each word the host model captured
  always @(posedge ref_clk_i) begin
    if (took === 1'b1) begin
      e = (q.size() > 0) ? q.pop_front() : 20'hFFFFF;
      check({low, ch, word}, e);
    end
  end
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    {wr_en_i, wr_addr_i, wr_data_i, lreq_valid_i, lreq_data_i, tc_i, slow} = '0;
    reset_i = 1'b1;
    void'($urandom(18116));
    repeat (20) @(negedge ref_clk_i);
    reset_i = 1'b0;
    lreq_valid_i = 2'h3;
    repeat (8) @(negedge ref_clk_i);
    check({lreq_ready_o, dma_req_o}, 0);
    lreq_valid_i = 2'h0;
    // A lane refuses words while its path-on bit is clear, even after its mode is written
    wr(LDM_LANE_B_MODE_OFS, 8'h45);
    check(lreq_ready_o, 0);
    wr(LDM_LANE_B_MODE_OFS, 8'hC5);
    repeat (3) push(0, 3'h5, 1'b1);
    drain();
    // Nine-word burst: the eighth ack forces a release, the ninth empties
    slow = 1'b1;
    wr(LDM_LANE_C_MODE_OFS, 8'h0B);
    wr(LDM_LANE_C_MODE_OFS, 8'h8B);
    for (int i = 0; i < 9; i++) push(1, 3'h3, i >= 7);
    drain();
    slow = 1'b0;
    wr(LDM_LANE_B_MODE_OFS, 8'h7E);
    wr(LDM_LANE_B_MODE_OFS, 8'hFE);
    repeat (2) push(0, 3'h6, 1'b1);
    drain();
    tc_i = 2'h1;
    repeat (2) @(negedge ref_clk_i);
    tc_i = 2'h0;
    repeat (6) @(negedge ref_clk_i);
    check({count_done_o, irq_o}, 3'h3);
    wr(LDM_STROBE_OFS, 8'h02);
    check({count_done_o, irq_o}, 0);
    tc_i = 2'h2;
    repeat (2) @(negedge ref_clk_i);
    tc_i = 2'h0;
    repeat (6) @(negedge ref_clk_i);
    check({count_done_o, irq_o}, 3'h4);
    wr(LDM_STROBE_OFS, 8'h04);
    check({count_done_o, irq_o}, 0);
    wr(4'hA, 8'h00);
    check(lreq_ready_o, 2'h3);
    wr(LDM_LANE_B_MODE_OFS, 8'h7E);
    check(lreq_ready_o, 2'h2);
    reset_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    reset_i = 1'b0;
    check({lreq_ready_o, count_done_o, irq_o, dma_req_o}, 0);
    final_report();
  end
endmodule : ldm_lane_bc_bench
